// file: cmst_host_model.sv
// Host chipset and strap resistor model facing the mode strap and tristate block.
module cmst_host_model (
  input  wire logic       clk_in,
  input  wire logic       pullup_oe_in,
  input  wire logic [7:0] strap_low_in,
  input  wire logic       suspend_in,
  output logic [7:0]      bus_out,
  output logic            float_n_out,
  output logic            power_line0_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pattern that changes every cycle, so a released bus never shows the strap again.
  logic [7:0] junk_q = 8'h5A;
  always_ff @(posedge clk_in) begin
    junk_q <= ~junk_q;
  end
  // pull-ups win where no pull-down is fitted.
  assign bus_out = pullup_oe_in ? ~strap_low_in : junk_q;
  assign float_n_out = ~suspend_in;
  // auto-toggle on: index 54h bit 0 clear, index 68h bit 0 set.
  localparam logic [7:0] PWR_CFG_54 = 8'h00;
  // recovery field at index 68h bits 3:2 holds binary 10.
  localparam logic [7:0] PWR_CFG_68 = 8'h09;
  logic auto_toggle;
  assign auto_toggle = ~PWR_CFG_54[0] & PWR_CFG_68[0] & (PWR_CFG_68[3:2] == 2'b10);
  // gate goes high, cutting the clock supply, only in suspend.
  assign power_line0_out = auto_toggle & suspend_in;
endmodule

// file: cmst_pkg.sv
// Package with mode codes and strap constants for the companion mode strap and tristate block.
package cmst_pkg;

  // ----------------------------------------------------------------
  // Strap patterns
  // ----------------------------------------------------------------
  localparam logic [7:0] CMST_STRAP_PRIMARY = 8'hED;
  localparam logic [7:0] CMST_STRAP_NB_A    = 8'hEE;
  localparam logic [7:0] CMST_STRAP_NB_B    = 8'hCE;

  // ----------------------------------------------------------------
  // Capture timing and reset values
  // ----------------------------------------------------------------
  // Synchroniser reset value, equal to the level that the pull-ups give.
  localparam logic [7:0] CMST_STRAP_IDLE    = 8'hFF;
  // Last count of the settle counter, reached when both stages hold pin data.
  localparam logic [1:0] CMST_SETTLE_LAST   = 2'h2;

  // ----------------------------------------------------------------
  // Decoded operating modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CMST_MODE_DESKTOP,
    CMST_MODE_PRIMARY,
    CMST_MODE_NB_A,
    CMST_MODE_NB_B
  } cmst_mode_t;

  // Group of outputs floated by the bus tristate control.
  typedef struct packed {
    logic [7:0] dma_grant_lines_n;
    logic       keyboard_select_n;
    logic       mem_read_n;
    logic       mem_write_n;
  } cmst_bus_grp_t;

  // Group of outputs floated by the scan output tristate control.
  typedef struct packed {
    logic [7:0] scan_data_out;
    logic       aux_zero_out_n;
  } cmst_scan_grp_t;

endpackage

// file: cmst_top.sv
// Strap mode decoder and suspend tristate control of the companion chip.
module cmst_top (
  input  wire logic                    clk_in,
  input  wire logic                    rst_in,
  input  wire logic [7:0]              peripheral_data_bus_in,
  input  wire logic                    bus_float_n_in,
  input  wire logic                    scan_out_float_n_in,
  input  wire logic                    boot_rom_select_n_in,
  input  wire logic                    rom_or_clock_select_n_in,
  input  wire logic                    write_or_keyboard_select_n_in,
  input  wire cmst_pkg::cmst_bus_grp_t  bus_grp_in,
  input  wire cmst_pkg::cmst_scan_grp_t scan_grp_in,
  output logic                         pullup_oe_out,
  output cmst_pkg::cmst_mode_t         mode_out,
  output logic                         notebook_mode_out,
  output cmst_pkg::cmst_bus_grp_t      bus_grp_out,
  output logic                         bus_grp_oe_out,
  output cmst_pkg::cmst_scan_grp_t     scan_grp_out,
  output logic                         scan_grp_oe_out,
  output logic                         data_bytes_oe_out
);
  import cmst_pkg::*;

  // ----------------------------------------------------------------
  // Strap helpers
  // ----------------------------------------------------------------
  // Decoding is shared by the capture path and the checks.
  function automatic cmst_mode_t strap_decode(input logic [7:0] pat);
    if (pat == CMST_STRAP_PRIMARY) return CMST_MODE_PRIMARY;
    else if (pat == CMST_STRAP_NB_A) return CMST_MODE_NB_A;
    else if (pat == CMST_STRAP_NB_B) return CMST_MODE_NB_B;
    else return CMST_MODE_DESKTOP;
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [7:0] strap_s1_q;
  logic [7:0] strap_s2_q;
  logic [7:0] strap_s1_d;
  logic [7:0] strap_s2_d;
  logic       in_rst_q;
  logic       in_rst_d;

  // The strap pins are asynchronous, so two stages precede the decoder.
  // Only the strap pins pass these stages; in_rst_q is a plain one-cycle
  // marker of reset release that the capture timing check keys on.
  always_comb begin
    strap_s1_d = peripheral_data_bus_in;
    strap_s2_d = strap_s1_q;
    in_rst_d   = 1'b0;
  end

  // Stages reset to ones, matching the idle level of the pull-ups.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      strap_s1_q <= CMST_STRAP_IDLE;
      strap_s2_q <= CMST_STRAP_IDLE;
      in_rst_q   <= 1'b1;
    end else begin
      strap_s1_q <= strap_s1_d;
      strap_s2_q <= strap_s2_d;
      in_rst_q   <= in_rst_d;
    end
  end

  // ----------------------------------------------------------------
  // Mode capture
  // ----------------------------------------------------------------
  logic [1:0] settle_q;
  logic [1:0] settle_d;
  logic       locked_q;
  logic       locked_d;
  cmst_mode_t mode_q;
  cmst_mode_t mode_d;

  // The asynchronous reset forbids loading a pin value, so the strap is
  // caught after release once both synchroniser stages hold pin data.
  // Limitation: the straps must be steady at the first edge after release; only that sample reaches the decoder.
  always_comb begin
    settle_d = settle_q;
    locked_d = locked_q;
    mode_d   = mode_q;
    if (!locked_q) begin
      if (settle_q != CMST_SETTLE_LAST) begin
        settle_d = settle_q + 2'h1;
      end else begin
        locked_d = 1'b1;
        mode_d   = strap_decode(strap_s2_q);
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      settle_q <= 2'h0;
      locked_q <= 1'b0;
      mode_q   <= CMST_MODE_DESKTOP;
    end else begin
      settle_q <= settle_d;
      locked_q <= locked_d;
      mode_q   <= mode_d;
    end
  end

  assign pullup_oe_out     = ~locked_q;
  assign mode_out          = mode_q;
  assign notebook_mode_out = (mode_q != CMST_MODE_DESKTOP);

  // ----------------------------------------------------------------
  // Tristate control
  // ----------------------------------------------------------------
  // Float controls stay combinational so suspend takes effect at once.
  // They skip the two-stage synchroniser on purpose: in suspend the clock
  // may be stopped, and the pins must still float as soon as the host asks.
  // The trade is a glitch on the enables if a control pin itself glitches.
  always_comb begin
    bus_grp_oe_out    = bus_float_n_in;
    scan_grp_oe_out   = scan_out_float_n_in;
    data_bytes_oe_out = bus_float_n_in & ~(boot_rom_select_n_in
                        & rom_or_clock_select_n_in & write_or_keyboard_select_n_in);
  end

  // values keep driving
  // Levels pass straight through; only the enables above decide floating.
  assign bus_grp_out  = bus_grp_in;
  assign scan_grp_out = scan_grp_in;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_CAPTURE: assert property (@(posedge clk_in) disable iff (rst_in)
    (!locked_q && settle_q == CMST_SETTLE_LAST)
    |=> (mode_q == strap_decode($past(strap_s2_q))))
    else $error("Mode not decoded from strap.");

  AST_DESKTOP: assert property (@(posedge clk_in) disable iff (rst_in)
    (!locked_q && settle_q == CMST_SETTLE_LAST && strap_s2_q != CMST_STRAP_PRIMARY
     && strap_s2_q != CMST_STRAP_NB_A && strap_s2_q != CMST_STRAP_NB_B)
    |=> !notebook_mode_out)
    else $error("Reserved strap gave notebook mode.");

  AST_PULLUP: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(locked_q) |-> !pullup_oe_out)
    else $error("Pull-up enable not dropped after capture.");

  AST_BUS_FLOAT: assert property (@(posedge clk_in) disable iff (rst_in)
    !bus_float_n_in |-> !bus_grp_oe_out && !data_bytes_oe_out)
    else $error("Bus group driven while floated.");

  AST_SCAN_FLOAT: assert property (@(posedge clk_in) disable iff (rst_in)
    scan_out_float_n_in == scan_grp_oe_out)
    else $error("Scan group enable wrong.");

  AST_DATA_FLOAT: assert property (@(posedge clk_in) disable iff (rst_in)
    (bus_float_n_in && boot_rom_select_n_in && rom_or_clock_select_n_in
     && write_or_keyboard_select_n_in) |-> !data_bytes_oe_out)
    else $error("Data bytes driven while idle.");

  AST_PASS: assert property (@(posedge clk_in) disable iff (rst_in)
    bus_grp_out == bus_grp_in && scan_grp_out == scan_grp_in)
    else $error("Output levels not passed through.");

  AST_HOLD: assert property (@(posedge clk_in) disable iff (rst_in)
    locked_q |=> locked_q && $stable(mode_q))
    else $error("Mode changed after capture.");

  AST_LOCK_TIME: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(in_rst_q) |-> ##2 locked_q)
    else $error("Mode not captured in time.");

  // ----------------------------------------------------------------
  // Drive-side and capture state checks
  // ----------------------------------------------------------------
  // The float checks above look at the floated case; AST_BUS_DRIVE and AST_DATA_DRIVE
  // make sure those outputs drive once the bus float control is released (the data bytes only while a select is low);
  // the rest check pull-up enable, pre-capture mode, notebook flag and counter range.
  AST_BUS_DRIVE: assert property (@(posedge clk_in) disable iff (rst_in)
    bus_float_n_in |-> bus_grp_oe_out)
    else $error("Bus group floated while control released.");

  AST_DATA_DRIVE: assert property (@(posedge clk_in) disable iff (rst_in)
    (bus_float_n_in && !(boot_rom_select_n_in && rom_or_clock_select_n_in
     && write_or_keyboard_select_n_in)) |-> data_bytes_oe_out)
    else $error("Data bytes floated during a selected access.");

  AST_LOCK_PULLUP: assert property (@(posedge clk_in) disable iff (rst_in)
    pullup_oe_out != locked_q)
    else $error("Pull-up enable disagrees with capture state.");

  AST_UNLOCKED_MODE: assert property (@(posedge clk_in) disable iff (rst_in)
    !locked_q |-> mode_q == CMST_MODE_DESKTOP && !notebook_mode_out)
    else $error("Mode shown before capture.");

  AST_NB_FLAG: assert property (@(posedge clk_in) disable iff (rst_in)
    notebook_mode_out == (mode_out == CMST_MODE_PRIMARY || mode_out == CMST_MODE_NB_A
     || mode_out == CMST_MODE_NB_B))
    else $error("Notebook flag disagrees with mode.");

  AST_SETTLE_RANGE: assert property (@(posedge clk_in) disable iff (rst_in)
    settle_q <= CMST_SETTLE_LAST)
    else $error("Capture counter out of range.");

endmodule

// file: tb.sv
// Self-checking bench for the strap decoder and tristate controls.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cmst_pkg::*;
  logic clk = 1'b0, rst = 1'b1, suspend = 1'b0, scan_fl_n = 1'b1;
  logic [7:0] strap_low = 8'h00, pd_bus;
  logic [2:0] sel_n = 3'h7;
  logic float_n, pu_oe, nb, bus_oe, scan_oe, data_oe, pwr0;
  cmst_bus_grp_t bus_in = '0, bus_o;
  cmst_scan_grp_t scan_in = '0, scan_o;
  cmst_mode_t mode;
  int error_cnt = 0, check_count = 0;
  initial forever #5 clk = ~clk;
  cmst_host_model HOST (.clk_in(clk), .pullup_oe_in(pu_oe), .strap_low_in(strap_low),
    .suspend_in(suspend), .bus_out(pd_bus), .float_n_out(float_n), .power_line0_out(pwr0));
  cmst_top DUT (.clk_in(clk), .rst_in(rst), .peripheral_data_bus_in(pd_bus),
    .bus_float_n_in(float_n), .scan_out_float_n_in(scan_fl_n),
    .boot_rom_select_n_in(sel_n[0]), .rom_or_clock_select_n_in(sel_n[1]),
    .write_or_keyboard_select_n_in(sel_n[2]), .bus_grp_in(bus_in), .scan_grp_in(scan_in),
    .pullup_oe_out(pu_oe), .mode_out(mode), .notebook_mode_out(nb), .bus_grp_out(bus_o),
    .bus_grp_oe_out(bus_oe), .scan_grp_out(scan_o), .scan_grp_oe_out(scan_oe),
    .data_bytes_oe_out(data_oe));
  // Compare one value and count the result.
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Strap a pattern through a reset and judge the captured mode.
  task automatic strap_case(input logic [7:0] pat, input cmst_mode_t m);
    strap_low = ~pat;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    chk("pullup_in_reset", 16'(pu_oe), 16'h1);
    chk("mode_in_reset", 16'(mode), 16'(CMST_MODE_DESKTOP));
    rst = 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("mode", 16'(mode), 16'(m));
    chk("notebook", 16'(nb), 16'(m != CMST_MODE_DESKTOP));
    chk("pullup_released", 16'(pu_oe), 16'h0);
    // The bus now toggles every cycle; the mode must not follow it.
    repeat (6) @(negedge clk);
    chk("mode_held", 16'(mode), 16'(m));
  endtask
  // Walk every combination of float controls and selects.
  task automatic float_case();
    for (int i = 0; i < 32; i++) begin
      suspend = i[0];
      scan_fl_n = i[1];
      sel_n = 3'(i >> 2);
      bus_in = cmst_bus_grp_t'(11'(i * 67));
      scan_in = cmst_scan_grp_t'(9'(i * 29));
      #2;
      chk("bus_oe", 16'(bus_oe), 16'(!i[0]));
      chk("scan_oe", 16'(scan_oe), 16'(i[1]));
      chk("data_oe", 16'(data_oe), 16'(!i[0] && (sel_n != 3'h7)));
      chk("power_line0", 16'(pwr0), 16'(i[0]));
      chk("bus_val", 16'(bus_o), 16'(bus_in));
      chk("scan_val", 16'(scan_o), 16'(scan_in));
      @(negedge clk);
    end
  endtask
  // Print the counts and the verdict, then stop.
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clk);
    strap_case(8'hED, CMST_MODE_PRIMARY);
    strap_case(8'hEE, CMST_MODE_NB_A);
    strap_case(8'hCE, CMST_MODE_NB_B);
    strap_case(8'hFF, CMST_MODE_DESKTOP);
    strap_case(8'hEC, CMST_MODE_DESKTOP);
    strap_case(8'h00, CMST_MODE_DESKTOP);
    float_case();
    tally_and_finish();
  end
endmodule
